// ===== design/fsac_defines.svh
`ifndef FSAC_DEFINES_SVH
`define FSAC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FSAC_ADDR_CFG 8'h20
`define FSAC_ADDR_STAT 8'h24
`define FSAC_ADDR_STALL 8'h25
`define FSAC_ADDR_SPIN 8'h26
`define FSAC_ADDR_DRV 8'h27
`define FSAC_ADDR_IEN 8'h29
`define FSAC_ADDR_LOCK 8'hEF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSAC_CFG_MASK 7
`define FSAC_CFG_DISTO 6
`define FSAC_CFG_WDC 5
`define FSAC_CFG_DRVCK 1
`define FSAC_CFG_USE_EXTERNAL_CLOCK 0
`define FSAC_ST_WATCH 7
`define FSAC_ST_DRV 2
`define FSAC_ST_SPIN 1
`define FSAC_ST_STALL 0
`define FSAC_LOCK_BIT 0

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define FSAC_CFG_RST 8'h00
`define FSAC_IEN_RST 5'h00
`define FSAC_FAN_CLR 5'h00
`define FSAC_FAN_ALL 5'h1F
`define FSAC_CFG_WMASK 8'hE3
`define FSAC_ZERO8 8'h00
`define FSAC_ZERO3 3'h0
`define FSAC_ZERO4 4'h0
`define FSAC_ZERO7 7'h00

`endif

// ===== design/fsac_pkg.sv
package fsac_pkg;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef logic [4:0] fsac_fan_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsac_req_s;

  typedef struct packed {
    fsac_fan_t stall;
    fsac_fan_t spin;
    fsac_fan_t drive;
  } fsac_fault_s;

endpackage

// ===== design/fsac_top.sv
`timescale 1ns/1ps
`include "fsac_defines.svh"

// Overview of operation
// - Global mask set: alert never asserted
// - Mask clear: any enabled status asserts alert
// - Timeout-disable bit turns off bus time-out
// - Continuous bit selects continuous watchdog mode
// - Drive-out bit drives internal clock on pin
// - Use-external bit times tach from pin
// - Drive-out overrides use-external, internal clock used
// - Watchdog expiry sets flag, forces full duty
// - Reading summary register clears watchdog flag
// - Summary drive-fail is OR of fan bits
// - Summary spin-fail is OR of fan bits
// - Summary stall is OR of fan bits
// - Stall bit set when tach exceeds maximum
// - Spin-fail bit set when spin-up fails
// - Drive-fail bit set when speed unreachable
// - Read clears only faults no longer present
// - Enabled fan faults assert the alert
// - Disabled fan faults update status, no alert
// - Configuration register obeys the software lock
// - Lock set makes locked registers read-only
// - Reset loads every register default

module fsac_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire fsac_pkg::fsac_req_s i_req,
  input wire fsac_pkg::fsac_fault_s i_fault,
  input wire logic i_wd_expire,
  input wire fsac_pkg::fsac_fan_t i_fan_reprog,
  input wire logic i_int_osc,
  input wire logic i_clk_pin,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_alert_n,
  output logic o_timeout_en,
  output logic o_wd_continuous,
  output logic o_tach_ext,
  output logic o_tach_clk,
  output logic o_clk_out,
  output logic o_clk_oe,
  output fsac_pkg::fsac_fan_t o_force_full
);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] cfg_r;
  fsac_pkg::fsac_fan_t ien_r;
  logic lock_r;
  logic watch_r;
  fsac_pkg::fsac_fan_t stall_r;
  fsac_pkg::fsac_fan_t spin_r;
  fsac_pkg::fsac_fan_t drv_r;
  logic [7:0] rd_nxt;
  logic pending;
  logic rd_stat;
  logic rd_stall;
  logic rd_spin;
  logic rd_drv;
  logic wr_cfg;
  logic any_stall;
  logic any_spin_fail;
  logic any_drive_fail;

  assign rd_stat = i_req.rd && (i_req.addr == `FSAC_ADDR_STAT);
  assign rd_stall = i_req.rd && (i_req.addr == `FSAC_ADDR_STALL);
  assign rd_spin = i_req.rd && (i_req.addr == `FSAC_ADDR_SPIN);
  assign rd_drv = i_req.rd && (i_req.addr == `FSAC_ADDR_DRV);
  assign wr_cfg = i_req.wr && (i_req.addr == `FSAC_ADDR_CFG);

  // ----------------------------------------
  // Lock and configuration
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_r <= 1'b0;
    end else if (i_req.wr && i_req.addr == `FSAC_ADDR_LOCK && i_req.wdata[`FSAC_LOCK_BIT]) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_r <= `FSAC_CFG_RST;
    end else if (wr_cfg && !lock_r) begin
      cfg_r <= i_req.wdata & `FSAC_CFG_WMASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ien_r <= `FSAC_IEN_RST;
    end else if (i_req.wr && i_req.addr == `FSAC_ADDR_IEN) begin
      ien_r <= i_req.wdata[4:0];
    end
  end

  // ----------------------------------------
  // Configuration outputs and clock pin
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_timeout_en <= 1'b1;
      o_wd_continuous <= 1'b0;
      o_tach_ext <= 1'b0;
      o_tach_clk <= 1'b0;
      o_clk_out <= 1'b0;
      o_clk_oe <= 1'b0;
    end else begin
      o_timeout_en <= !cfg_r[`FSAC_CFG_DISTO];
      o_wd_continuous <= cfg_r[`FSAC_CFG_WDC];
      o_tach_ext <= cfg_r[`FSAC_CFG_USE_EXTERNAL_CLOCK] && !cfg_r[`FSAC_CFG_DRVCK];
      if (cfg_r[`FSAC_CFG_USE_EXTERNAL_CLOCK] && !cfg_r[`FSAC_CFG_DRVCK]) begin
        o_tach_clk <= i_clk_pin;
      end else begin
        o_tach_clk <= i_int_osc;
      end
      o_clk_oe <= cfg_r[`FSAC_CFG_DRVCK];
      o_clk_out <= cfg_r[`FSAC_CFG_DRVCK] ? i_int_osc : 1'b0;
    end
  end

  // ----------------------------------------
  // Watchdog flag and forced full duty
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      watch_r <= 1'b0;
    end else if (i_wd_expire) begin
      watch_r <= 1'b1;
    end else if (rd_stat) begin
      watch_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_force_full <= `FSAC_FAN_CLR;
    end else if (i_wd_expire) begin
      o_force_full <= `FSAC_FAN_ALL;
    end else begin
      o_force_full <= o_force_full & ~i_fan_reprog;
    end
  end

  // ----------------------------------------
  // Per-fan sticky fault flags
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_fan
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          stall_r[g] <= 1'b0;
          spin_r[g] <= 1'b0;
          drv_r[g] <= 1'b0;
        end else begin
          stall_r[g] <= i_fault.stall[g] || (stall_r[g] && !rd_stall);
          spin_r[g] <= i_fault.spin[g] || (spin_r[g] && !rd_spin);
          drv_r[g] <= i_fault.drive[g] || (drv_r[g] && !rd_drv);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Summary bits
  // ----------------------------------------
  assign any_stall = |stall_r;
  assign any_spin_fail = |spin_r;
  assign any_drive_fail = |drv_r;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_nxt = `FSAC_ZERO8;
    case (i_req.addr)
      `FSAC_ADDR_CFG: rd_nxt = cfg_r;
      `FSAC_ADDR_STAT: rd_nxt = {watch_r, `FSAC_ZERO4, any_drive_fail, any_spin_fail, any_stall};
      `FSAC_ADDR_STALL: rd_nxt = {`FSAC_ZERO3, stall_r};
      `FSAC_ADDR_SPIN: rd_nxt = {`FSAC_ZERO3, spin_r};
      `FSAC_ADDR_DRV: rd_nxt = {`FSAC_ZERO3, drv_r};
      `FSAC_ADDR_IEN: rd_nxt = {`FSAC_ZERO3, ien_r};
      `FSAC_ADDR_LOCK: rd_nxt = {`FSAC_ZERO7, lock_r};
      default: rd_nxt = `FSAC_ZERO8;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `FSAC_ZERO8;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) begin
        o_rdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------
  // Alert
  // ----------------------------------------
  assign pending = watch_r || |(ien_r & (stall_r | spin_r | drv_r));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alert_n <= 1'b1;
    end else begin
      o_alert_n <= !(pending && !cfg_r[`FSAC_CFG_MASK]);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mask_blocks: assert property (cfg_r[`FSAC_CFG_MASK] |=> o_alert_n)
    else $error("alert asserted while masked");
  a_alert_on: assert property (!cfg_r[`FSAC_CFG_MASK] && pending |=> !o_alert_n)
    else $error("alert missing for pending status");
  a_enabled_fault: assert property (!cfg_r[`FSAC_CFG_MASK] && |(ien_r & stall_r) |=> !o_alert_n)
    else $error("enabled stall gave no alert");
  a_disabled_quiet: assert property (!watch_r && ien_r == `FSAC_FAN_CLR |=> o_alert_n)
    else $error("disabled fault raised alert");
  a_alert_release: assert property (!pending |=> o_alert_n)
    else $error("alert held without cause");
  a_timeout_dis: assert property (cfg_r[`FSAC_CFG_DISTO] |=> !o_timeout_en)
    else $error("time-out still enabled");
  a_wd_mode: assert property (##1 o_wd_continuous == $past(cfg_r[`FSAC_CFG_WDC]))
    else $error("watchdog mode mismatch");
  a_clk_drive: assert property (cfg_r[`FSAC_CFG_DRVCK] |=> o_clk_oe && !o_tach_ext)
    else $error("clock drive-out wrong");
  a_clk_ext: assert property (cfg_r[`FSAC_CFG_USE_EXTERNAL_CLOCK] && !cfg_r[`FSAC_CFG_DRVCK] |=> o_tach_ext)
    else $error("external clock not used");
  a_wd_force: assert property (i_wd_expire |=> watch_r && o_force_full == `FSAC_FAN_ALL)
    else $error("watchdog expiry not handled");
  a_watch_clr: assert property (rd_stat && !i_wd_expire |=> !watch_r)
    else $error("watchdog flag not cleared");
  a_sum_drv: assert property (rd_stat |=> o_rdata[`FSAC_ST_DRV] == $past(any_drive_fail))
    else $error("summary drive-fail wrong");
  a_sum_spin: assert property (rd_stat |=> o_rdata[`FSAC_ST_SPIN] == $past(any_spin_fail))
    else $error("summary spin-fail wrong");
  a_sum_stall: assert property (rd_stat |=> o_rdata[`FSAC_ST_STALL] == $past(any_stall))
    else $error("summary stall wrong");
  a_stall_set: assert property (i_fault.stall[0] |=> stall_r[0])
    else $error("stall flag not set");
  a_spin_set: assert property (i_fault.spin[4] |=> spin_r[4])
    else $error("spin flag not set");
  a_drv_set: assert property (i_fault.drive[2] |=> drv_r[2])
    else $error("drive flag not set");
  a_rc_keep: assert property (rd_stall |=> stall_r == $past(i_fault.stall))
    else $error("read-clear wrong");
  a_lock_hold: assert property (lock_r && wr_cfg |=> $stable(cfg_r))
    else $error("locked config written");
  a_unimpl_zero: assert property (cfg_r[4:2] == `FSAC_ZERO3)
    else $error("unimplemented config bits set");
  a_timeout_on: assert property (!cfg_r[`FSAC_CFG_DISTO] |=> o_timeout_en)
    else $error("time-out not enabled");
  a_clk_input: assert property (!cfg_r[`FSAC_CFG_DRVCK] |=> !o_clk_oe && !o_clk_out)
    else $error("clock pin driven as input");
  a_int_osc: assert property (!cfg_r[`FSAC_CFG_USE_EXTERNAL_CLOCK] |=> !o_tach_ext)
    else $error("external clock used unasked");
  a_enabled_spin: assert property (!cfg_r[`FSAC_CFG_MASK] && |(ien_r & spin_r) |=> !o_alert_n)
    else $error("enabled spin fail gave no alert");
  a_enabled_drv: assert property (!cfg_r[`FSAC_CFG_MASK] && |(ien_r & drv_r) |=> !o_alert_n)
    else $error("enabled drive fail gave no alert");
  a_force_hold: assert property (!i_wd_expire && i_fan_reprog == `FSAC_FAN_CLR |=> $stable(o_force_full))
    else $error("forced duty dropped early");
  a_watch_read: assert property (rd_stat |=> o_rdata[`FSAC_ST_WATCH] == $past(watch_r))
    else $error("watchdog flag read wrong");

  // ----------------------------------------
  // Checks on flags and lock
  // ----------------------------------------
  a_stall_all: assert property (i_fault.stall != `FSAC_FAN_CLR
    |=> (stall_r & $past(i_fault.stall)) == $past(i_fault.stall))
    else $error("stall flag missed");
  a_spin_all: assert property (i_fault.spin != `FSAC_FAN_CLR
    |=> (spin_r & $past(i_fault.spin)) == $past(i_fault.spin))
    else $error("spin flag missed");
  a_drv_all: assert property (i_fault.drive != `FSAC_FAN_CLR
    |=> (drv_r & $past(i_fault.drive)) == $past(i_fault.drive))
    else $error("drive flag missed");
  a_spin_rc: assert property (rd_spin |=> spin_r == $past(i_fault.spin))
    else $error("spin read-clear wrong");
  a_drv_rc: assert property (rd_drv |=> drv_r == $past(i_fault.drive))
    else $error("drive read-clear wrong");
  a_stat_unimpl: assert property (rd_stat |=> o_rdata[6:3] == `FSAC_ZERO4)
    else $error("summary unused bits set");
  a_fan_unimpl: assert property (rd_stall || rd_spin || rd_drv |=> o_rdata[7:5] == `FSAC_ZERO3)
    else $error("fan flag unused bits set");
  a_cfg_write: assert property (wr_cfg && !lock_r |=> cfg_r == ($past(i_req.wdata) & `FSAC_CFG_WMASK))
    else $error("open config write lost");
  a_lock_set: assert property (i_req.wr && i_req.addr == `FSAC_ADDR_LOCK
    && i_req.wdata[`FSAC_LOCK_BIT] |=> lock_r)
    else $error("lock not engaged");
  a_lock_sticky: assert property (lock_r |=> lock_r)
    else $error("lock released");

endmodule

// ===== testbench/fsac_host.sv
`timescale 1ns/1ps
module fsac_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output fsac_pkg::fsac_req_s o_req
);
  // ----
  // Single-byte host accesses, idle bus shows inverted fields
  // ----
  initial begin
    o_req = 18'h00000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge i_clk);
    o_req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h5A};
    @(negedge i_clk);
    o_req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hA5};
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// ===== testbench/fsac_top_tb.sv
`timescale 1ns/1ps
module fsac_top_tb;
  logic i_clk;
  logic i_resetn;
  fsac_pkg::fsac_req_s req;
  fsac_pkg::fsac_fault_s i_fault;
  logic i_wd_expire;
  fsac_pkg::fsac_fan_t i_fan_reprog;
  logic i_int_osc;
  logic i_clk_pin;
  logic [7:0] o_rdata;
  logic o_rvalid, o_alert_n, o_timeout_en, o_wd_continuous;
  logic o_tach_ext, o_tach_clk, o_clk_out, o_clk_oe;
  fsac_pkg::fsac_fan_t o_force_full;
  int n_errors;
  int cmp_count;
  int k;
  int f;
  logic [7:0] d;
  logic [7:0] c;
  logic v;

  fsac_top fsac_top_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .i_fault(i_fault),
    .i_wd_expire(i_wd_expire), .i_fan_reprog(i_fan_reprog), .i_int_osc(i_int_osc),
    .i_clk_pin(i_clk_pin), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_alert_n(o_alert_n),
    .o_timeout_en(o_timeout_en), .o_wd_continuous(o_wd_continuous), .o_tach_ext(o_tach_ext),
    .o_tach_clk(o_tach_clk), .o_clk_out(o_clk_out), .o_clk_oe(o_clk_oe), .o_force_full(o_force_full));
  fsac_host fsac_host_i (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_req(req));

  // ----
  // Checking and closing
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    fsac_host_i.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  function automatic logic [1:0] tach_exp(input logic [7:0] w);
    logic ext;
    ext = w[0] & ~w[1];
    return {ext, ext ? ~w[2] : w[2]};
  endfunction
  task automatic results();
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    n_errors++;
    results();
  end

  // ----
  // Tests
  // ----
  initial begin
    i_resetn = 1'h0;
    i_fault = 15'h0000;
    i_wd_expire = 1'h0;
    i_fan_reprog = 5'h00;
    i_int_osc = 1'h0;
    i_clk_pin = 1'h0;
    void'($urandom(40));
    repeat (6) @(negedge i_clk);
    i_resetn = 1'h1;
    chk({6'h00, o_alert_n, o_timeout_en}, 8'h03);
    for (k = 0; k < 8; k++) rdchk(8'h20 + 8'(k == 7 ? 9 : k), 8'h00);
    $display("reset test done");
    for (k = 0; k < 6; k++) begin
      c = 8'($urandom());
      if (k < 4) c[1:0] = 2'(k);
      fsac_host_i.wr(8'h20, c);
      i_int_osc = c[2];
      i_clk_pin = ~c[2];
      rdchk(8'h20, c & 8'hE3);
      repeat (2) @(negedge i_clk);
      chk({7'h00, o_timeout_en}, {7'h00, ~c[6]});
      chk({7'h00, o_wd_continuous}, {7'h00, c[5]});
      chk({6'h00, o_clk_oe, o_clk_out}, {6'h00, c[1], c[1] & c[2]});
      chk({6'h00, o_tach_ext, o_tach_clk}, {6'h00, tach_exp(c)});
      chk({7'h00, o_alert_n}, 8'h01);
    end
    fsac_host_i.wr(8'h20, 8'h00);
    fsac_host_i.wr(8'h29, 8'h1F);
    $display("config test done");
    for (k = 0; k < 3; k++) begin
      f = $urandom_range(4, 0);
      i_fault = 15'h0001 << (f + 5 * (2 - k));
      repeat (3) @(negedge i_clk);
      chk({7'h00, o_alert_n}, 8'h00);
      rdchk(8'h24, 8'(1 << k));
      rdchk(8'h25 + 8'(k), 8'(1 << f));
      rdchk(8'h25 + 8'(k), 8'(1 << f));
      i_fault = 15'h0000;
      rdchk(8'h25 + 8'(k), 8'(1 << f));
      rdchk(8'h25 + 8'(k), 8'h00);
      rdchk(8'h24, 8'h00);
      chk({7'h00, o_alert_n}, 8'h01);
    end
    fsac_host_i.wr(8'h29, 8'h00);
    i_fault = 15'h0400 << f;
    repeat (3) @(negedge i_clk);
    chk({7'h00, o_alert_n}, 8'h01);
    rdchk(8'h24, 8'h01);
    fsac_host_i.wr(8'h29, 8'h1F);
    fsac_host_i.wr(8'h20, 8'h80);
    repeat (3) @(negedge i_clk);
    chk({7'h00, o_alert_n}, 8'h01);
    fsac_host_i.wr(8'h20, 8'h00);
    repeat (2) @(negedge i_clk);
    chk({7'h00, o_alert_n}, 8'h00);
    i_fault = 15'h0000;
    rdchk(8'h25, 8'(1 << f));
    @(negedge i_clk);
    chk({7'h00, o_alert_n}, 8'h01);
    $display("fault test done");
    i_wd_expire = 1'h1;
    @(negedge i_clk);
    i_wd_expire = 1'h0;
    @(negedge i_clk);
    chk({3'h0, o_force_full}, 8'h1F);
    chk({7'h00, o_alert_n}, 8'h00);
    rdchk(8'h24, 8'h80);
    rdchk(8'h24, 8'h00);
    chk({3'h0, o_force_full}, 8'h1F);
    f = $urandom_range(4, 0);
    i_fan_reprog = 5'(1 << f);
    @(negedge i_clk);
    i_fan_reprog = 5'h00;
    chk({3'h0, o_force_full}, {3'h0, 5'h1F & ~5'(1 << f)});
    $display("watchdog test done");
    fsac_host_i.wr(8'hEF, 8'h01);
    fsac_host_i.wr(8'h20, 8'h63);
    rdchk(8'h20, 8'h00);
    rdchk(8'h30, 8'h00);
    $display("lock test done");
    results();
  end
endmodule
